// file: verilog/cte_defines.svh
`ifndef CTE_DEFINES_SVH
`define CTE_DEFINES_SVH

// Word indices of the register map (byte address = 4 * index)
`define CTE_OFF_DLC0     6'h00
`define CTE_OFF_DLC1     6'h01
`define CTE_OFF_DLC2     6'h02
`define CTE_OFF_TEC      6'h03
`define CTE_OFF_FLAGS    6'h04
`define CTE_OFF_EN       6'h05
`define CTE_OFF_CSTAT    6'h06
`define CTE_OFF_COMM     6'h07
`define CTE_OFF_MODE     6'h08

// Frame control byte layout
`define CTE_DLC_RTR_BIT  6
`define CTE_DLC_MASK     8'h4F
`define CTE_LEN_MAX      4'h8
`define CTE_RST_DLC      8'h00

// Transmit fault counting
`define CTE_RST_TEC      8'h00
`define CTE_TEC_MAX      8'hFF
`define CTE_TEC_INC      8'h08
`define CTE_TEC_DEC      8'h01
`define CTE_TEC_WARN     8'h5F
`define CTE_TEC_PASS     8'h7F
`define CTE_RECOV_CNT    8'h80

// Peripheral flag / enable bit positions
`define CTE_FLG_RX0      0
`define CTE_FLG_RX1      1
`define CTE_FLG_TX0      2
`define CTE_FLG_TX1      3
`define CTE_FLG_TX2      4
`define CTE_FLG_ERR      5
`define CTE_FLG_WAKE     6
`define CTE_FLG_INVAL    7

// Communication status bit positions
`define CTE_CS_EWARN     0
`define CTE_CS_RXWARN    1
`define CTE_CS_TXWARN    2
`define CTE_CS_RXBP      3
`define CTE_CS_TX_ERROR_PASSIVE_FLAG      4
`define CTE_CS_BUS_OFF_FLAG      5
`define CTE_CS_RXOVF     6

// Interrupt codes, lower value = higher priority except CTE_IC_FIFO_RX, which is ranked in place of RX0
`define CTE_IC_NONE      5'h00
`define CTE_IC_ERR       5'h01
`define CTE_IC_TX2       5'h02
`define CTE_IC_TX1       5'h03
`define CTE_IC_TX0       5'h04
`define CTE_IC_RX1       5'h05
`define CTE_IC_RX0       5'h06
`define CTE_IC_WAKE      5'h07
`define CTE_IC_INVAL     5'h08
`define CTE_IC_FIFO_RX   5'h10

`endif

// file: verilog/cte_pkg.sv
package cte_pkg;

	typedef enum logic [1:0] {
		CTE_LEGACY   = 2'h0,
		CTE_ENHANCED = 2'h1,
		CTE_FIFO     = 2'h2
	} cte_mode_e;

	// Gray along active -> passive -> bus-off
	typedef enum logic [1:0] {
		CTE_ACTIVE  = 2'b00,
		CTE_PASSIVE = 2'b01,
		CTE_BUSOFF  = 2'b11
	} cte_ec_e;

	typedef struct packed {
		cte_ec_e     st;
		logic [7:0]  cnt;
		logic [7:0]  rec;
	} cte_tec_s;

	typedef struct packed {
		logic            ack;
		logic [31:0]     rdat;
		logic [2:0][7:0] dlc;
		logic [7:0]      flags;
		logic [7:0]      en;
		cte_mode_e       mode;
		logic            rx_ovf;
		logic [4:0]      prev;
		logic            tx_rtr;
		logic [3:0]      tx_dlc;
		logic [3:0]      tx_bytes;
	} cte_top_s;

endpackage

// file: verilog/cte_link_if.sv
`timescale 1ns/1ns
`default_nettype none

interface cte_link_if;
	logic       ce;
	logic       tx_err;
	logic       tx_ok;
	logic       idle11;
	logic [7:0] count;
	logic       bus_off;
	logic       passive;
	logic       warn;
	logic [7:0] pending;
	logic [1:0] mode;
	logic [4:0] code;

	modport top (output ce, tx_err, tx_ok, idle11, pending, mode,
		input count, bus_off, passive, warn, code);
	modport tec (input ce, tx_err, tx_ok, idle11,
		output count, bus_off, passive, warn);
	modport enc (input pending, mode, output code);
endinterface

`default_nettype wire

// file: verilog/cte_tec.sv
`timescale 1ns/1ns
`default_nettype none
`include "cte_defines.svh"

module cte_tec #(
	parameter logic [7:0] RECOVER_N = `CTE_RECOV_CNT
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	cte_link_if.tec   lnk
);
	cte_pkg::cte_tec_s s;
	cte_pkg::cte_tec_s nxt;

	always_comb
	begin
		nxt = s;
		case (s.st)
			cte_pkg::CTE_ACTIVE, cte_pkg::CTE_PASSIVE:
			begin
				// An error in the same bit time as a success counts as an error
				if (lnk.tx_err)
				begin
					if (s.cnt > (`CTE_TEC_MAX - `CTE_TEC_INC))
					begin
						nxt.st  = cte_pkg::CTE_BUSOFF; // R05
						nxt.cnt = `CTE_TEC_MAX;
						nxt.rec = `CTE_RST_TEC;
					end
					else
						nxt.cnt = s.cnt + `CTE_TEC_INC; // R19
				end
				else if (lnk.tx_ok && s.cnt != `CTE_RST_TEC)
					nxt.cnt = s.cnt - `CTE_TEC_DEC; // R19
				if (nxt.st != cte_pkg::CTE_BUSOFF)
					nxt.st = (nxt.cnt > `CTE_TEC_PASS) ? cte_pkg::CTE_PASSIVE
						: cte_pkg::CTE_ACTIVE;
			end
			cte_pkg::CTE_BUSOFF:
			begin
				if (lnk.idle11)
				begin
					if (s.rec == RECOVER_N - `CTE_TEC_DEC)
					begin
						nxt.st  = cte_pkg::CTE_ACTIVE; // R06
						nxt.cnt = `CTE_RST_TEC;
						nxt.rec = `CTE_RST_TEC;
					end
					else
						nxt.rec = s.rec + `CTE_TEC_DEC; // R06
				end
			end
			default:
				nxt = '0;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			s <= '0; // R04
		else if (lnk.ce)
			s <= nxt;
	end

	assign lnk.count   = s.cnt;
	assign lnk.bus_off = (s.st == cte_pkg::CTE_BUSOFF); // R15
	assign lnk.passive = (s.cnt > `CTE_TEC_PASS); // R16
	assign lnk.warn    = (s.cnt > `CTE_TEC_WARN);

	a_tec_overflow: assert property (@(posedge clk_i) disable iff (rst_i) // R05
		(lnk.ce && !lnk.bus_off && lnk.tx_err && s.cnt > 8'hF7) |=> lnk.bus_off)
		else $error("overflow did not enter bus-off");
	a_tec_step_up: assert property (@(posedge clk_i) disable iff (rst_i) // R19
		(lnk.ce && !lnk.bus_off && lnk.tx_err && s.cnt <= 8'hF7)
		|=> s.cnt == $past(s.cnt) + 8'h08)
		else $error("error did not add eight");
	a_bo_recover: assert property (@(posedge clk_i) disable iff (rst_i) // R06
		(lnk.ce && lnk.bus_off && lnk.idle11 && s.rec == RECOVER_N - 8'h01)
		|=> (s.cnt == 8'h00 && !lnk.bus_off))
		else $error("bus-off recovery did not clear count");
	a_bo_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R06
		(lnk.bus_off && !(lnk.ce && lnk.idle11)) |=> lnk.bus_off && s.cnt == 8'hFF)
		else $error("bus-off left without recovery");
	c_bus_off: cover property (@(posedge clk_i) disable iff (rst_i) $rose(lnk.bus_off));
	c_recover: cover property (@(posedge clk_i) disable iff (rst_i) $fell(lnk.bus_off));
endmodule

`default_nettype wire

// file: verilog/cte_interrupt_code.sv
`timescale 1ns/1ns
`default_nettype none
`include "cte_defines.svh"

module cte_interrupt_code (
	cte_link_if.enc lnk
);
	logic legacy;

	assign legacy = (lnk.mode == cte_pkg::CTE_LEGACY);

	// Only enabled flags arrive here, so disabled sources never show
	always_comb
	begin
		lnk.code = `CTE_IC_NONE; // R17
		if (lnk.pending[`CTE_FLG_ERR])
			lnk.code = `CTE_IC_ERR;
		else if (legacy && lnk.pending[`CTE_FLG_TX2])
			lnk.code = `CTE_IC_TX2;
		else if (legacy && lnk.pending[`CTE_FLG_TX1])
			lnk.code = `CTE_IC_TX1;
		else if (lnk.pending[`CTE_FLG_TX0])
			lnk.code = `CTE_IC_TX0;
		else if (legacy && lnk.pending[`CTE_FLG_RX1])
			lnk.code = `CTE_IC_RX1;
		else if (lnk.pending[`CTE_FLG_RX0])
			lnk.code = (lnk.mode == cte_pkg::CTE_FIFO) ? `CTE_IC_FIFO_RX // R18
				: `CTE_IC_RX0;
		else if (lnk.pending[`CTE_FLG_WAKE])
			lnk.code = `CTE_IC_WAKE;
		else if (!legacy && lnk.pending[`CTE_FLG_INVAL])
			lnk.code = `CTE_IC_INVAL;
	end
endmodule

`default_nettype wire

// file: verilog/cte_top.sv
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "cte_defines.svh"

// How it works
// R01: Frame control bit 6 sets the remote-request bit of frames from that buffer.
// R02: Low four bits give payload bytes 0 to 8; codes above 8 reserved.
// R03: Frame control bits 7, 5 and 4 read zero and ignore writes.
// R04: Transmit fault count is 8-bit, read-only, zero after reset.
// R05: Fault count overflow enters bus-off and stops bus participation.
// R06: In bus-off, 128 runs of eleven recessive bits clear the count.
// R07: Each interrupt source has its own enable bit.
// R08: Eight interrupt flags in one register, eight enables in another.
// R09: Read-only interrupt code in controller status shows the serviced source.
// R10: Error flag set by overrun, warnings, error-passive or bus-off.
// R11: Software reads communication status to find the error cause.
// R12: Enhanced and FIFO modes share one transmit and one receive flag.
// R13: Receive sources: received, wake-up, overrun, receive warning, receive passive.
// R14: Transmit sources: transmitted, transmit warning, transmit passive, bus-off.
// R15: Bus-off flag set while the fault count has overflowed.
// R16: Transmit error-passive flag set while fault count exceeds 127.
// R17: Code gives higher priority lower values, only enabled sources counted; FIFO receive code 10000 is ranked above wake-up and invalid.
// R18: FIFO mode receive interrupt always gives code 10000.
// R19: Fault count goes up eight on errors, down one on success.
// R20: Flags stay until cleared; request raised while flag and enable coincide.
module cte_top (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [1:0]  tx_sel_i,
	output logic             tx_rtr_o,
	output logic      [3:0]  tx_dlc_o,
	output logic      [3:0]  tx_bytes_o,
	input  wire logic [2:0]  tx_done_i,
	input  wire logic        tx_err_i,
	input  wire logic        idle11_i,
	input  wire logic [1:0]  rx_done_i,
	input  wire logic        rx_overrun_i,
	input  wire logic        rx_warn_i,
	input  wire logic        rx_passive_i,
	input  wire logic        wake_i,
	input  wire logic        rx_invalid_i,
	output logic             bus_on_o,
	output logic             irq_o
);
	cte_pkg::cte_top_s s;
	cte_pkg::cte_top_s nxt;
	cte_link_if        lnk ();
	logic [5:0]        widx;
	logic [4:0]        lv;
	logic [4:0]        rise;
	logic [7:0]        evt;
	logic [7:0]        clr;
	logic [7:0]        comm;
	logic [7:0]        sel_dlc;
	logic              wr;
	logic              rd;

	cte_tec u_tec (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.lnk   (lnk)
	);

	cte_interrupt_code u_interrupt_code (
		.lnk (lnk)
	);

	assign lnk.ce      = ce_i;
	assign lnk.tx_err  = tx_err_i;
	assign lnk.tx_ok   = |tx_done_i; // R19
	assign lnk.idle11  = idle11_i; // R06
	assign lnk.pending = s.flags & s.en; // R07
	assign lnk.mode    = s.mode;

	always_comb
	begin
		nxt  = s;
		widx = wb_adr_i[7:2];
		// A write lands on the edge where the master sees ack
		wr   = wb_cyc_i & wb_stb_i & wb_we_i & s.ack & wb_sel_i[0];
		rd   = wb_cyc_i & wb_stb_i & ~wb_we_i & ~s.ack;
		nxt.ack = wb_cyc_i & wb_stb_i & ~s.ack;

		// Level sources raise the error flag on their rising edge only
		lv   = {lnk.bus_off, lnk.passive, lnk.warn, rx_passive_i, rx_warn_i};
		rise = lv & ~s.prev;
		nxt.prev = lv;

		evt = 8'h00;
		evt[`CTE_FLG_ERR]   = rx_overrun_i | (|rise); // R10
		evt[`CTE_FLG_WAKE]  = wake_i; // R13
		evt[`CTE_FLG_INVAL] = rx_invalid_i;
		if (s.mode == cte_pkg::CTE_LEGACY)
		begin
			evt[`CTE_FLG_RX0] = rx_done_i[0]; // R13
			evt[`CTE_FLG_RX1] = rx_done_i[1];
			evt[`CTE_FLG_TX0] = tx_done_i[0]; // R14
			evt[`CTE_FLG_TX1] = tx_done_i[1];
			evt[`CTE_FLG_TX2] = tx_done_i[2];
		end
		else
		begin
			evt[`CTE_FLG_RX0] = |rx_done_i; // R12
			evt[`CTE_FLG_TX0] = |tx_done_i; // R12
		end

		clr = 8'h00;
		if (wr && widx == `CTE_OFF_FLAGS)
			clr = wb_dat_i[7:0];
		// Set wins over a clear in the same cycle so no event is lost
		nxt.flags = (s.flags & ~clr) | evt; // R20 R08
		nxt.rx_ovf = (s.rx_ovf & ~(wr && widx == `CTE_OFF_COMM
			&& wb_dat_i[`CTE_CS_RXOVF])) | rx_overrun_i;

		if (wr)
		begin
			case (widx)
				`CTE_OFF_DLC0: nxt.dlc[0] = wb_dat_i[7:0] & `CTE_DLC_MASK; // R03
				`CTE_OFF_DLC1: nxt.dlc[1] = wb_dat_i[7:0] & `CTE_DLC_MASK; // R03
				`CTE_OFF_DLC2: nxt.dlc[2] = wb_dat_i[7:0] & `CTE_DLC_MASK; // R03
				`CTE_OFF_EN: nxt.en = wb_dat_i[7:0]; // R07 R08
				`CTE_OFF_MODE:
				begin
					// The unused mode encoding is refused, mode stays as it was
					if (wb_dat_i[1:0] != 2'h3)
						nxt.mode = cte_pkg::cte_mode_e'(wb_dat_i[1:0]);
				end
				default:
					nxt.mode = s.mode;
			endcase
		end

		if (rd)
		begin
			case (widx)
				`CTE_OFF_DLC0: nxt.rdat = {24'h000000, s.dlc[0]};
				`CTE_OFF_DLC1: nxt.rdat = {24'h000000, s.dlc[1]};
				`CTE_OFF_DLC2: nxt.rdat = {24'h000000, s.dlc[2]};
				`CTE_OFF_TEC: nxt.rdat = {24'h000000, lnk.count}; // R04
				`CTE_OFF_FLAGS: nxt.rdat = {24'h000000, s.flags};
				`CTE_OFF_EN: nxt.rdat = {24'h000000, s.en};
				`CTE_OFF_CSTAT: nxt.rdat = {27'h0000000, lnk.code}; // R09
				`CTE_OFF_COMM: nxt.rdat = {24'h000000, comm}; // R11
				`CTE_OFF_MODE: nxt.rdat = {30'h00000000, s.mode};
				default: nxt.rdat = 32'h00000000;
			endcase
		end

		// Frame fields handed to the transmitter; reserved lengths send eight bytes
		sel_dlc = (tx_sel_i == 2'h3) ? `CTE_RST_DLC : s.dlc[tx_sel_i];
		nxt.tx_rtr   = sel_dlc[`CTE_DLC_RTR_BIT]; // R01
		nxt.tx_dlc   = sel_dlc[3:0]; // R02
		nxt.tx_bytes = (sel_dlc[3:0] > `CTE_LEN_MAX) ? `CTE_LEN_MAX : sel_dlc[3:0]; // R02
	end

	always_comb
	begin
		comm = 8'h00;
		comm[`CTE_CS_EWARN]  = lnk.warn | rx_warn_i;
		comm[`CTE_CS_RXWARN] = rx_warn_i;
		comm[`CTE_CS_TXWARN] = lnk.warn;
		comm[`CTE_CS_RXBP]   = rx_passive_i;
		comm[`CTE_CS_TX_ERROR_PASSIVE_FLAG]   = lnk.passive; // R16
		comm[`CTE_CS_BUS_OFF_FLAG]   = lnk.bus_off; // R15
		comm[`CTE_CS_RXOVF]  = s.rx_ovf;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			s <= '0;
		else if (ce_i)
			s <= nxt;
	end

	assign wb_ack_o   = s.ack;
	assign wb_dat_o   = s.rdat;
	assign tx_rtr_o   = s.tx_rtr;
	assign tx_dlc_o   = s.tx_dlc;
	assign tx_bytes_o = s.tx_bytes;
	assign bus_on_o   = ~lnk.bus_off; // R05
	assign irq_o      = |(s.flags & s.en); // R20

	a_wb_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o [*1])
		else $error("ack not a single cycle after request");
	a_dlc_unused: assert property (@(posedge clk_i) disable iff (rst_i) // R03
		(wb_ack_o && !wb_we_i && wb_adr_i[7:2] <= 6'h02)
		|-> (wb_dat_o & 32'hFFFFFFB0) == 32'h00000000)
		else $error("unused frame control bits read nonzero");
	a_rtr_follow: assert property (@(posedge clk_i) disable iff (rst_i) // R01
		(ce_i && tx_sel_i == 2'h1) |=> tx_rtr_o == $past(s.dlc[1][6]))
		else $error("remote request not taken from buffer");
	a_len_limit: assert property (@(posedge clk_i) disable iff (rst_i) // R02
		(ce_i && tx_sel_i == 2'h0 && s.dlc[0][3:0] >= 4'h8) |=> tx_bytes_o == 4'h8)
		else $error("payload length beyond eight bytes");
	a_err_source: assert property (@(posedge clk_i) disable iff (rst_i) // R10
		(ce_i && rx_overrun_i) |=> s.flags[5] && s.rx_ovf)
		else $error("overrun did not set error flag");
	a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // R20
		(s.flags[6] && !(wr && widx == 6'h04 && wb_dat_i[6])) |=> s.flags[6])
		else $error("flag dropped without a clear");
	a_irq_raise: assert property (@(posedge clk_i) disable iff (rst_i) // R20
		(ce_i && wake_i && s.en[6]) |=> irq_o)
		else $error("enabled event did not raise request");
	a_shared_tx: assert property (@(posedge clk_i) disable iff (rst_i) // R12
		(ce_i && s.mode != cte_pkg::CTE_LEGACY && tx_done_i != 3'h0) |=> s.flags[2])
		else $error("shared transmit flag not set");
	a_fifo_code: assert property (@(posedge clk_i) disable iff (rst_i) // R18
		(s.mode == cte_pkg::CTE_FIFO && lnk.pending[2:0] == 3'h1 && !lnk.pending[5])
		|-> lnk.code == 5'h10)
		else $error("FIFO receive code wrong");
	a_code_prio: assert property (@(posedge clk_i) disable iff (rst_i) // R17
		lnk.pending[5] |-> lnk.code == 5'h01)
		else $error("error interrupt not highest priority");
	a_code_masked: assert property (@(posedge clk_i) disable iff (rst_i) // R17
		(lnk.pending == 8'h00) |-> lnk.code == 5'h00 && !irq_o)
		else $error("code shows a disabled source");
	c_fifo_rx: cover property (@(posedge clk_i) disable iff (rst_i) lnk.code == 5'h10);
	c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
	c_clear: cover property (@(posedge clk_i) disable iff (rst_i) $fell(s.flags[5]));
endmodule

`default_nettype wire

// file: dv/cte_bus_model.sv
`timescale 1ns/1ns
`default_nettype none

// Far-side bus nodes: each event code becomes a one-cycle pulse at the next edge
module cte_bus_model (
	input  wire logic       clk_i,
	input  wire logic [3:0] op_i,
	output logic      [2:0] tx_done_o,
	output logic            tx_err_o,
	output logic            idle11_o,
	output logic      [1:0] rx_done_o,
	output logic            rx_overrun_o,
	output logic            wake_o,
	output logic            rx_invalid_o
);
	always_ff @(posedge clk_i)
	begin
		tx_err_o     <= (op_i == 4'h1);
		tx_done_o    <= {op_i == 4'h4, op_i == 4'h3, op_i == 4'h2};
		idle11_o     <= (op_i == 4'h5);
		rx_done_o    <= {op_i == 4'h7, op_i == 4'h6};
		rx_overrun_o <= (op_i == 4'h8);
		wake_o       <= (op_i == 4'h9);
		rx_invalid_o <= (op_i == 4'hA);
	end
endmodule

`default_nettype wire

// file: dv/can_tx_length_error_interrupts_bench.sv
`timescale 1ns/1ns
`default_nettype none

module can_tx_length_error_interrupts_bench;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc = 1'b0;
	logic        wb_stb = 1'b0;
	logic        wb_we = 1'b0;
	logic [3:0]  wb_sel = 4'h0;
	logic [7:0]  wb_adr = 8'h00;
	logic [31:0] wb_dat = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [1:0]  tx_sel = 2'h2;
	logic        tx_rtr_o;
	logic [3:0]  tx_dlc_o;
	logic [3:0]  tx_bytes_o;
	logic [3:0]  op = 4'h0;
	logic [2:0]  tx_done;
	logic        tx_err;
	logic        idle11;
	logic [1:0]  rx_done;
	logic        rx_ovr;
	logic        rx_warn = 1'b0;
	logic        rx_pass = 1'b0;
	logic        wake;
	logic        rx_inv;
	logic        bus_on_o;
	logic        irq_o;
	int          n_errors = 0;
	int          checks = 0;

	always #10 clk_i = ~clk_i;

	cte_bus_model bus (.clk_i(clk_i), .op_i(op), .tx_done_o(tx_done), .tx_err_o(tx_err),
		.idle11_o(idle11), .rx_done_o(rx_done), .rx_overrun_o(rx_ovr), .wake_o(wake),
		.rx_invalid_o(rx_inv));

	cte_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
		.wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_sel_i(tx_sel),
		.tx_rtr_o(tx_rtr_o), .tx_dlc_o(tx_dlc_o), .tx_bytes_o(tx_bytes_o),
		.tx_done_i(tx_done), .tx_err_i(tx_err), .idle11_i(idle11), .rx_done_i(rx_done),
		.rx_overrun_i(rx_ovr), .rx_warn_i(rx_warn), .rx_passive_i(rx_pass),
		.wake_i(wake), .rx_invalid_i(rx_inv), .bus_on_o(bus_on_o), .irq_o(irq_o));

	task automatic test_done();
		if (n_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Classic single cycle; called just after a rising edge
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int i;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_sel <= 4'hF;
		wb_adr <= a;
		wb_dat <= wd;
		for (i = 0; i < 40; i++)
		begin
			@(posedge clk_i);
			if (wb_ack_o === 1'b1)
				break;
		end
		rd = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_sel <= 4'h0;
		if (i == 40)
		begin
			n_errors++;
			test_done();
		end
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [31:0] d;
		wb(1'b1, a, v, d);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		wb(1'b0, a, 32'h0, d);
		chk(d, e);
	endtask

	// Pulses spaced by an idle cycle, then room for the error flag's extra edge
	task automatic ev(input logic [3:0] code, input int n);
		repeat (n)
		begin
			op <= code;
			@(posedge clk_i);
			op <= 4'h0;
			@(posedge clk_i);
		end
		repeat (4) @(posedge clk_i);
	endtask

	initial
	begin
		logic [31:0] d;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rc(8'h0C, 32'h0);
		rc(8'h10, 32'h0);
		chk({31'h0, bus_on_o}, 32'h1);
		wr(8'h00, 32'hFFFF_FFFF);
		rc(8'h00, 32'h4F);
		wr(8'h0C, 32'h55);
		rc(8'h0C, 32'h0);
		for (int i = 0; i < 16; i++)
		begin
			// Rotate through all three buffers so select values 0 to 2 are exercised
			wr({4'h0, 2'(i % 3), 2'b00}, {24'h0, 1'b1, i[0], 2'b11, i[3:0]});
			tx_sel <= 2'(i % 3);
			@(posedge clk_i);
			rc({4'h0, 2'(i % 3), 2'b00}, {25'h0, i[0], 2'b00, i[3:0]});
			chk({31'h0, tx_rtr_o}, {31'h0, i[0]});
			chk({28'h0, tx_dlc_o}, i[3:0]);
			chk({28'h0, tx_bytes_o}, (i > 8) ? 32'h8 : i);
		end
		// Legacy mode: flags, enables and priority code
		ev(4'h4, 1);
		rc(8'h10, 32'h10);
		chk({31'h0, irq_o}, 32'h0);
		rc(8'h18, 32'h0);
		wr(8'h14, 32'h14);
		chk({31'h0, irq_o}, 32'h1);
		rc(8'h18, 32'h2);
		ev(4'h2, 1);
		rc(8'h10, 32'h14);
		rc(8'h18, 32'h2);
		wr(8'h10, 32'h10);
		rc(8'h18, 32'h4);
		wr(8'h10, 32'hFF);
		for (int c = 6; c < 11; c++)
			ev(c[3:0], 1);
		ev(4'h3, 1);
		rc(8'h10, 32'hEB);
		wr(8'h14, 32'hFF);
		rc(8'h18, 32'h1);
		wr(8'h10, 32'h20);
		rc(8'h18, 32'h3);
		wr(8'h10, 32'h08);
		rc(8'h18, 32'h5);
		wr(8'h10, 32'h02);
		rc(8'h18, 32'h6);
		wr(8'h10, 32'h01);
		rc(8'h18, 32'h7);
		wr(8'h10, 32'h40);
		rc(8'h18, 32'h0);
		wr(8'h10, 32'hFF);
		ev(4'h9, 1);
		chk({31'h0, irq_o}, 32'h1);
		wr(8'h10, 32'hFF);
		wr(8'h1C, 32'h40);
		rc(8'h1C, 32'h0);
		// Fault counting through warning, passive, bus-off and recovery
		ev(4'h1, 12);
		rc(8'h0C, 32'h60);
		rc(8'h1C, 32'h05);
		rc(8'h10, 32'h20);
		rc(8'h18, 32'h1);
		wr(8'h10, 32'hFF);
		ev(4'h1, 4);
		rc(8'h1C, 32'h15);
		rc(8'h10, 32'h20);
		ev(4'h2, 1);
		rc(8'h0C, 32'h7F);
		rc(8'h1C, 32'h05);
		ev(4'h1, 16);
		rc(8'h0C, 32'hFF);
		chk({31'h0, bus_on_o}, 32'h1);
		ev(4'h1, 1);
		chk({31'h0, bus_on_o}, 32'h0);
		wb(1'b0, 8'h1C, 32'h0, d);
		chk(d & 32'h20, 32'h20);
		rc(8'h0C, 32'hFF);
		ev(4'h5, 127);
		chk({31'h0, bus_on_o}, 32'h0);
		ev(4'h5, 1);
		chk({31'h0, bus_on_o}, 32'h1);
		rc(8'h0C, 32'h0);
		wr(8'h10, 32'hFF);
		rx_warn <= 1'b1;
		ev(4'h0, 0);
		rc(8'h1C, 32'h03);
		rx_pass <= 1'b1;
		ev(4'h0, 0);
		rc(8'h1C, 32'h0B);
		rc(8'h10, 32'h20);
		rx_warn <= 1'b0;
		rx_pass <= 1'b0;
		wr(8'h10, 32'hFF);
		// Shared buffer flags and FIFO code
		wr(8'h20, 32'h1);
		ev(4'h3, 1);
		rc(8'h10, 32'h04);
		rc(8'h18, 32'h4);
		wr(8'h10, 32'hFF);
		ev(4'h7, 1);
		rc(8'h10, 32'h01);
		rc(8'h18, 32'h6);
		wr(8'h20, 32'h2);
		rc(8'h18, 32'h10);
		wr(8'h10, 32'hFF);
		ev(4'h8, 1);
		rc(8'h10, 32'h20);
		rc(8'h1C, 32'h40);
		wr(8'h10, 32'hFF);
		ev(4'hA, 1);
		rc(8'h18, 32'h8);
		wr(8'h20, 32'h3);
		rc(8'h20, 32'h2);
		rc(8'hFC, 32'h0);
		// Second reset in mid-run must drop sticky state
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rc(8'h10, 32'h0);
		rc(8'h1C, 32'h0);
		chk({31'h0, irq_o}, 32'h0);
		test_done();
	end
endmodule

`default_nettype wire
